/* design/ust_pkg.sv */
// Constants and types for the sleep, time-out, break and baud block.
// Assumes one core clock; FIFOs and the serial engines live elsewhere.
package ust_pkg;

    // ==========================================================
    // Register addresses on the plain host port
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_IER = 4'h1;
    localparam logic [3:0] ADDR_EFR = 4'h2;
    localparam logic [3:0] ADDR_LCR = 4'h3;
    localparam logic [3:0] ADDR_MCR = 4'h4;
    localparam logic [3:0] ADDR_LSR = 4'h5;

    // ==========================================================
    // Field positions and reset values
    localparam int IER_SLEEP_BIT = 4;
    localparam int EFR_ENH_BIT = 4;
    localparam int LCR_DLAB_BIT = 7;
    localparam int LCR_BREAK_BIT = 6;
    localparam int LCR_PAR_BIT = 3;
    localparam int LCR_STOP_BIT = 2;
    localparam int MCR_CLKDIV_BIT = 7;
    localparam int LSR_DATA_BIT = 0;
    localparam int LSR_BREAK_BIT = 4;
    localparam int LSR_THRE_BIT = 5;
    localparam int LSR_TEMT_BIT = 6;
    localparam logic [7:0] LCR_RESET = 8'h1d;
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ==========================================================
    // Timing in 16x ticks
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [7:0] TICKS_PER_BIT = 8'h10;
    localparam logic [7:0] STOP_ONE = 8'h10;
    localparam logic [7:0] STOP_HALF_MORE = 8'h18;
    localparam logic [7:0] STOP_TWO = 8'h20;
    localparam logic [7:0] WORD_BASE = 8'h05;
    localparam int TIMEOUT_CHAR_SHIFT = 2;
    localparam logic SUPPORT_IR_WAKE = 1'b1;

    // ==========================================================
    // Types
    typedef enum logic {ST_AWAKE, ST_ASLEEP} ust_sleep_type;

    typedef struct packed {
        logic rx_fifo_empty;
        logic rx_below_trigger;
        logic rx_trigger_hit;
        logic tx_fifo_empty;
        logic tsr_empty;
        logic line_error;
        logic modem_irq;
        logic stop_mid;
    } ust_status_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ust_host_type;

endpackage

/* design/ust_top.sv */
// Sleep control, receive time-out, break and 16x baud generator of a UART.
// Assumes the host port, status inputs and tx_serial are on core_clk;
// rx_pin and modem_pins are asynchronous pins.
// Operation
// - Enabled low INTERRUPT_ENABLE_REG bits drive interrupt output
// - All four low bits zero means polled
// - Sleep needs enhanced bit and sleep bit
// - Sleep only when line idle, all empty
// - Asleep stops the UART clock enable
// - Wake on rx edge, modem change, data write
// - Rx wake also works in infrared mode
// - General pins never wake; their irq passes
// - Time-out after four idle character times
// - Time-out restarts at stop, FIFO read
// - Break when rx low past one frame
// - Set-break bit forces serial output low
// - Sixteen-bit divisor, one to maximum
// - Optional divide-by-four prescaler, reset one
// - Baud tick runs at sixteen times rate
// - Divisor built from low, high bytes
// - Zero divisor gives no baud tick
// - One tick feeds transmitter and receiver
// - Divisor bytes reachable only with latch bit
// - Prescaler bit writable only when enhanced
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module ust_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire ust_pkg::ust_host_type host,
    output logic [7:0] rdata,
    input wire ust_pkg::ust_status_type status,
    input wire logic gpio_irq,
    input wire logic ir_mode,
    input wire logic rx_pin,
    input wire logic [3:0] modem_pins,
    input wire logic tx_serial,
    output logic tx_pin,
    output logic irq_out,
    output logic uart_clk_en,
    output logic baud16_tick,
    output logic rx_timeout,
    output logic break_seen
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] interrupt_enable_reg;
        logic [7:0] line_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] dll;
        logic [7:0] divisor_high_byte;
        logic [7:0] rdata;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] clean;
        ust_pkg::ust_sleep_type sleep;
        logic [1:0] pre_cnt;
        logic [15:0] div_cnt;
        logic tick;
        logic [9:0] to_cnt;
        logic to_flag;
        logic [7:0] brk_cnt;
        logic brk_flag;
        logic tx;
        logic irq;
    } ust_state_type;

    ust_state_type state_reg;
    ust_state_type state_next;

    logic dlab;
    logic enh_key;
    logic [15:0] divisor;
    logic [7:0] char_ticks;
    logic [9:0] timeout_ticks;
    logic sleep_en;
    logic thr_write;
    logic rx_read;
    logic lsr_read;
    logic rx_edge;
    logic modem_edge;
    logic wake;
    logic pend_no_thr;
    logic irq_pending;
    logic can_sleep;
    logic pre_tick;
    logic running;
    logic [4:0] clean_new;
    localparam logic [7:0] ZERO8 = ust_pkg::ZERO_BYTE;

    // ==========================================================
    // Decode and derived values
    assign dlab = state_reg.line_control_reg[ust_pkg::LCR_DLAB_BIT];
    assign enh_key = state_reg.line_control_reg == ust_pkg::LCR_ENH_KEY;
    assign divisor = {state_reg.divisor_high_byte, state_reg.dll};
    assign sleep_en = state_reg.enhanced_feature_reg[ust_pkg::EFR_ENH_BIT]
        & state_reg.interrupt_enable_reg[ust_pkg::IER_SLEEP_BIT];
    assign thr_write = host.wr & !dlab & (host.addr == ust_pkg::ADDR_DATA);
    assign rx_read = host.rd & !dlab & (host.addr == ust_pkg::ADDR_DATA);
    assign lsr_read = host.rd & (host.addr == ust_pkg::ADDR_LSR);

    // Frame length in ticks: start, data, parity, stop
    always_comb
    begin
        logic [7:0] bits;
        logic [7:0] stop;
        stop = ust_pkg::STOP_TWO;
        bits = 8'h01 + ust_pkg::WORD_BASE + {6'h00, state_reg.line_control_reg[1:0]}
            + {7'h00, state_reg.line_control_reg[ust_pkg::LCR_PAR_BIT]};
        if (!state_reg.line_control_reg[ust_pkg::LCR_STOP_BIT])
            stop = ust_pkg::STOP_ONE;
        else if (state_reg.line_control_reg[1:0] == 2'h0)
            stop = ust_pkg::STOP_HALF_MORE;
        char_ticks = 8'((bits * ust_pkg::TICKS_PER_BIT) + stop);
    end
    assign timeout_ticks = {2'h0, char_ticks} << ust_pkg::TIMEOUT_CHAR_SHIFT;

    // Pin edges only count once the last two stages agree
    always_comb
    begin
        clean_new = state_reg.clean;
        for (int i = 0; i < 5; i++)
            if (state_reg.s2[i] == state_reg.s3[i])
                clean_new[i] = state_reg.s3[i];
    end
    // Rx wake is allowed in infrared mode when supported
    assign rx_edge = (clean_new[0] != state_reg.clean[0])
        & (!ir_mode | ust_pkg::SUPPORT_IR_WAKE);
    assign modem_edge = clean_new[4:1] != state_reg.clean[4:1];
    // General pins are not a wake source
    assign wake = rx_edge | modem_edge | thr_write | !sleep_en;

    // Pending sources other than transmit-holding-empty
    assign pend_no_thr =
        (state_reg.interrupt_enable_reg[0] & (status.rx_trigger_hit | state_reg.to_flag))
        | (state_reg.interrupt_enable_reg[2] & (status.line_error | state_reg.brk_flag))
        | (state_reg.interrupt_enable_reg[3] & status.modem_irq)
        | gpio_irq;
    // Irq from enabled sources only, but the general pin irq also passes in polled mode
    assign irq_pending = pend_no_thr
        | (state_reg.interrupt_enable_reg[1] & status.tx_fifo_empty);
    assign can_sleep = sleep_en & state_reg.clean[0]
        & (state_reg.brk_cnt == ZERO8)
        & status.tx_fifo_empty & status.tsr_empty
        & status.rx_fifo_empty & !pend_no_thr;

    // Clock enable rises at once on wake, ahead of the event
    assign running = (state_reg.sleep == ust_pkg::ST_AWAKE) | wake;
    assign pre_tick = !state_reg.modem_control_reg[ust_pkg::MCR_CLKDIV_BIT]
        | (state_reg.pre_cnt == ust_pkg::PRESCALE_LAST);

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.s1 = {modem_pins, rx_pin};
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.clean = clean_new;
        state_next.tick = 1'b0;
        state_next.rdata = ZERO8;

        // Register writes
        if (host.wr)
        begin
            unique case (host.addr)
                ust_pkg::ADDR_DATA:
                    if (dlab)
                        state_next.dll = host.wdata;
                ust_pkg::ADDR_IER:
                    if (dlab)
                        state_next.divisor_high_byte = host.wdata;
                    else
                        state_next.interrupt_enable_reg = host.wdata;
                ust_pkg::ADDR_EFR:
                    if (enh_key)
                        state_next.enhanced_feature_reg = host.wdata;
                ust_pkg::ADDR_LCR:
                    state_next.line_control_reg = host.wdata;
                ust_pkg::ADDR_MCR:
                begin
                    state_next.modem_control_reg[6:0] = host.wdata[6:0];
                    if (state_reg.enhanced_feature_reg[ust_pkg::EFR_ENH_BIT])
                        state_next.modem_control_reg[ust_pkg::MCR_CLKDIV_BIT] =
                            host.wdata[ust_pkg::MCR_CLKDIV_BIT];
                end
                default:
                    state_next.modem_control_reg = state_reg.modem_control_reg;
            endcase
        end

        // Register reads, answered next cycle
        if (host.rd)
        begin
            unique case (host.addr)
                ust_pkg::ADDR_DATA:
                    state_next.rdata = dlab ? state_reg.dll : ZERO8;
                ust_pkg::ADDR_IER:
                    state_next.rdata = dlab ? state_reg.divisor_high_byte : state_reg.interrupt_enable_reg;
                ust_pkg::ADDR_EFR:
                    state_next.rdata = enh_key ? state_reg.enhanced_feature_reg : ZERO8;
                ust_pkg::ADDR_LCR:
                    state_next.rdata = state_reg.line_control_reg;
                ust_pkg::ADDR_MCR:
                    state_next.rdata = state_reg.modem_control_reg;
                ust_pkg::ADDR_LSR:
                begin
                    state_next.rdata[ust_pkg::LSR_DATA_BIT] =
                        !status.rx_fifo_empty;
                    state_next.rdata[ust_pkg::LSR_BREAK_BIT] =
                        state_reg.brk_flag;
                    state_next.rdata[ust_pkg::LSR_THRE_BIT] =
                        status.tx_fifo_empty;
                    state_next.rdata[ust_pkg::LSR_TEMT_BIT] =
                        status.tx_fifo_empty & status.tsr_empty;
                end
                default:
                    state_next.rdata = ZERO8;
            endcase
        end

        // Sleep machine
        unique case (state_reg.sleep)
            ust_pkg::ST_AWAKE:
                if (can_sleep & !wake)
                    state_next.sleep = ust_pkg::ST_ASLEEP;
            ust_pkg::ST_ASLEEP:
                if (wake)
                    state_next.sleep = ust_pkg::ST_AWAKE;
        endcase

        // Baud generator, frozen while the UART clock is off
        if (running)
        begin
            state_next.pre_cnt = 2'(state_reg.pre_cnt + 2'h1);
            if (divisor == 16'h0000)
                state_next.div_cnt = 16'h0000;
            else if (pre_tick)
            begin
                if (state_reg.div_cnt >= 16'(divisor - 16'h0001))
                begin
                    state_next.div_cnt = 16'h0000;
                    state_next.tick = 1'b1;
                end
                else
                    state_next.div_cnt = 16'(state_reg.div_cnt + 16'h0001);
            end
        end

        // Receive time-out; a restart never hides a new set
        if (status.stop_mid | rx_read)
        begin
            state_next.to_cnt = 10'h000;
            state_next.to_flag = 1'b0;
        end
        else if (state_reg.tick)
        begin
            if (status.rx_fifo_empty | !status.rx_below_trigger)
                state_next.to_cnt = 10'h000;
            else if (state_reg.to_cnt != timeout_ticks)
                state_next.to_cnt = 10'(state_reg.to_cnt + 10'h001);
        end
        if (state_reg.tick & !status.rx_fifo_empty
            & status.rx_below_trigger
            & (state_reg.to_cnt == 10'(timeout_ticks - 10'h001)))
            state_next.to_flag = 1'b1;

        // Break detect: low for more than a frame; set beats clear
        if (lsr_read)
            state_next.brk_flag = 1'b0;
        if (state_reg.clean[0])
            state_next.brk_cnt = ZERO8;
        else if (state_reg.tick & state_reg.brk_cnt != 8'hff)
            state_next.brk_cnt = 8'(state_reg.brk_cnt + 8'h01);
        if (state_reg.brk_cnt > char_ticks & !state_reg.clean[0])
            state_next.brk_flag = 1'b1;

        // Break output and interrupt line
        state_next.tx = state_reg.line_control_reg[ust_pkg::LCR_BREAK_BIT]
            ? 1'b0 : tx_serial;
        state_next.irq = irq_pending;
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.line_control_reg <= ust_pkg::LCR_RESET;
            state_reg.s1 <= 5'h1f;
            state_reg.s2 <= 5'h1f;
            state_reg.s3 <= 5'h1f;
            state_reg.clean <= 5'h1f;
            state_reg.tx <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    // Outputs, all from flops except the clock enable
    assign rdata = state_reg.rdata;
    assign tx_pin = state_reg.tx;
    assign irq_out = state_reg.irq;
    assign uart_clk_en = running;
    assign baud16_tick = state_reg.tick;
    assign rx_timeout = state_reg.to_flag;
    assign break_seen = state_reg.brk_flag;

    // ==========================================================
    // Checks
    property p_polled;
        @(posedge core_clk) disable iff (reset)
        (state_reg.interrupt_enable_reg[3:0] == 4'h0 && !gpio_irq) |=> !irq_out;
    endproperty
    a_polled: assert property (p_polled)
        else $error("irq in polled mode");

    property p_irq;
        @(posedge core_clk) disable iff (reset)
        (state_reg.interrupt_enable_reg[1] && status.tx_fifo_empty) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled source gave no irq");

    property p_sleep_en;
        @(posedge core_clk) disable iff (reset)
        $rose(state_reg.sleep == ust_pkg::ST_ASLEEP) |-> $past(sleep_en);
    endproperty
    a_sleep_en: assert property (p_sleep_en)
        else $error("slept while sleep disabled");

    property p_enter;
        @(posedge core_clk) disable iff (reset)
        $rose(state_reg.sleep == ust_pkg::ST_ASLEEP)
        |-> $past(status.rx_fifo_empty && status.tx_fifo_empty);
    endproperty
    a_enter: assert property (p_enter)
        else $error("slept with data pending");

    property p_clk;
        @(posedge core_clk) disable iff (reset)
        (state_reg.sleep == ust_pkg::ST_ASLEEP && !wake) |-> !uart_clk_en;
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock ran while asleep");

    property p_wake;
        @(posedge core_clk) disable iff (reset)
        (state_reg.sleep == ust_pkg::ST_ASLEEP && thr_write)
        |-> uart_clk_en ##1 state_reg.sleep == ust_pkg::ST_AWAKE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("write did not wake");

    property p_break_tx;
        @(posedge core_clk) disable iff (reset)
        state_reg.line_control_reg[ust_pkg::LCR_BREAK_BIT] |=> !tx_pin;
    endproperty
    a_break_tx: assert property (p_break_tx)
        else $error("tx not held low in break");

    property p_zero_div;
        @(posedge core_clk) disable iff (reset)
        (divisor == 16'h0000)[*2] |-> !baud16_tick;
    endproperty
    a_zero_div: assert property (p_zero_div)
        else $error("tick with zero divisor");

    property p_dlab;
        @(posedge core_clk) disable iff (reset)
        (host.wr && !dlab && host.addr == ust_pkg::ADDR_DATA)
        |=> $stable(state_reg.dll);
    endproperty
    a_dlab: assert property (p_dlab)
        else $error("divisor written without latch bit");

    property p_mcr7;
        @(posedge core_clk) disable iff (reset)
        !state_reg.enhanced_feature_reg[ust_pkg::EFR_ENH_BIT]
        |=> $stable(state_reg.modem_control_reg[ust_pkg::MCR_CLKDIV_BIT]);
    endproperty
    a_mcr7: assert property (p_mcr7)
        else $error("prescaler bit changed unlocked");

endmodule

`default_nettype wire

/* dv/ust_far_model.sv */
// Far-side model: remote serial line, modem pins and FIFO status.
// Assumes core_clk is the block's clock; all changes follow its edge.
`timescale 1ns/1ns
`default_nettype none

module ust_far_model (
    input wire logic core_clk,
    output ust_pkg::ust_status_type status,
    output logic rx_pin,
    output logic [3:0] modem_pins,
    output logic tx_serial
);
    // ==========================================================
    // Idle line high, FIFOs and shift register empty
    initial
    begin
        status = '0;
        status.rx_fifo_empty = 1'b1;
        status.tx_fifo_empty = 1'b1;
        status.tsr_empty = 1'b1;
        rx_pin = 1'b1;
        modem_pins = 4'h0;
        tx_serial = 1'b1;
    end

    // ==========================================================
    // Commands from the bench, applied just after an edge
    task automatic set_fifo(input logic empty, input logic below);
        @(posedge core_clk);
        status.rx_fifo_empty <= empty;
        status.rx_below_trigger <= below;
    endtask

    // Raises or drops every non-transmit interrupt source at once
    task automatic set_src(input logic on);
        @(posedge core_clk);
        status.rx_trigger_hit <= on;
        status.line_error <= on;
        status.modem_irq <= on;
    endtask

    // Stop-bit centre is a single-cycle event
    task automatic stop_pulse();
        @(posedge core_clk);
        status.stop_mid <= 1'b1;
        @(posedge core_clk);
        status.stop_mid <= 1'b0;
    endtask

    task automatic set_line(input logic v);
        @(posedge core_clk);
        rx_pin <= v;
    endtask

    // Short start-bit-like glitch, enough to wake but not a break
    task automatic pulse_line();
        @(posedge core_clk);
        rx_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        rx_pin <= 1'b1;
    endtask

    task automatic flip_modem();
        @(posedge core_clk);
        modem_pins <= ~modem_pins;
    endtask

    task automatic set_tx(input logic v);
        @(posedge core_clk);
        tx_serial <= v;
    endtask

    // Transmit FIFO and shift register both holding data
    task automatic set_tx_busy(input logic busy);
        @(posedge core_clk);
        status.tx_fifo_empty <= !busy;
        status.tsr_empty <= !busy;
    endtask
endmodule

`default_nettype wire

/* dv/ust_top_test.sv */
// Self-checking bench for the sleep, time-out, break and baud block.
// Assumes ust_far_model stands for the serial side and FIFO status.
`timescale 1ns/1ns
`default_nettype none

module ust_top_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    ust_pkg::ust_host_type host = '0;
    ust_pkg::ust_status_type status;
    logic gpio_irq = 1'b0;
    logic ir_mode = 1'b0;
    logic rx_pin;
    logic [3:0] modem_pins;
    logic tx_serial;
    logic [7:0] rdata;
    logic tx_pin, irq_out, uart_clk_en, baud16_tick, rx_timeout, break_seen;
    int err_count = 0;
    int tests_run = 0;
    int en_cycles = 0;
    int tick_cnt = 0;
    int de, dt;

    ust_top i_dut (.core_clk(core_clk), .reset(reset), .host(host),
        .rdata(rdata), .status(status), .gpio_irq(gpio_irq),
        .ir_mode(ir_mode), .rx_pin(rx_pin), .modem_pins(modem_pins),
        .tx_serial(tx_serial), .tx_pin(tx_pin), .irq_out(irq_out),
        .uart_clk_en(uart_clk_en), .baud16_tick(baud16_tick),
        .rx_timeout(rx_timeout), .break_seen(break_seen));

    ust_far_model i_far (.core_clk(core_clk), .status(status),
        .rx_pin(rx_pin), .modem_pins(modem_pins), .tx_serial(tx_serial));

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    // Counts of enabled cycles and ticks, read as deltas
    always @(posedge core_clk)
    begin
        if (uart_clk_en !== 1'b0)
            en_cycles <= en_cycles + 1;
        if (baud16_tick !== 1'b0)
            tick_cnt <= tick_cnt + 1;
    end

    // ==========================================================
    // Helpers
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // Sample a little after the edge so registered outputs settle
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        host.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        host <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        host.rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic span(input int n);
        int e0, t0;
        e0 = en_cycles;
        t0 = tick_cnt;
        cyc(n);
        de = en_cycles - e0;
        dt = tick_cnt - t0;
    endtask

    // Divisor change then a tick count over a whole number of periods
    task automatic set_div(input logic [7:0] lo, input logic [7:0] hi);
        wr_reg(ust_pkg::ADDR_LCR, 8'h80);
        wr_reg(ust_pkg::ADDR_DATA, lo);
        wr_reg(ust_pkg::ADDR_IER, hi);
        wr_reg(ust_pkg::ADDR_LCR, 8'h03);
    endtask

    task automatic rate(input int n, input int exp);
        cyc(300);
        span(n);
        check(16'(dt), 16'(exp));
    endtask

    // Line held low past one frame of the given format
    task automatic brk(input logic [7:0] line_control_reg, input int frame);
        wr_reg(ust_pkg::ADDR_LCR, line_control_reg);
        i_far.set_line(1'b0);
        cyc(frame - 10);
        check(16'(break_seen), 16'h0000);
        cyc(20);
        check(16'(break_seen), 16'h0001);
        i_far.set_line(1'b1);
        cyc(5);
        chk_rd(ust_pkg::ADDR_LSR, 8'h70);
        chk_rd(ust_pkg::ADDR_LSR, 8'h60);
    endtask

    // ==========================================================
    // Watchdog, well beyond the expected run of some 6000 cycles
    initial
    begin
        #(50 * 20000);
        err_count++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        chk_rd(ust_pkg::ADDR_LCR, 8'h1d);
        chk_rd(ust_pkg::ADDR_LSR, 8'h60);
        check(16'(tx_pin), 16'h0001);
        span(100);
        check(16'(dt), 16'h0000);
        // Sleep bit alone must not stop the clock
        wr_reg(ust_pkg::ADDR_IER, 8'h10);
        cyc(10);
        span(10);
        check(16'(de), 16'h000a);
        wr_reg(ust_pkg::ADDR_IER, 8'h00);
        // Tick rates for divisors 256, 3 and 1, with the prescaler locked and then enabled
        set_div(8'h00, 8'h01);
        rate(768, 3);
        set_div(8'h03, 8'h00);
        wr_reg(ust_pkg::ADDR_DATA, 8'h07);
        rate(300, 100);
        wr_reg(ust_pkg::ADDR_MCR, 8'h80);
        rate(300, 100);
        wr_reg(ust_pkg::ADDR_LCR, 8'hbf);
        wr_reg(ust_pkg::ADDR_EFR, 8'h10);
        wr_reg(ust_pkg::ADDR_LCR, 8'h03);
        wr_reg(ust_pkg::ADDR_MCR, 8'h80);
        rate(300, 25);
        wr_reg(ust_pkg::ADDR_MCR, 8'h00);
        set_div(8'h01, 8'h00);
        rate(300, 300);
        // Set-break overrides transmit data
        i_far.set_tx(1'b0);
        cyc(3);
        check(16'(tx_pin), 16'h0000);
        wr_reg(ust_pkg::ADDR_LCR, 8'h43);
        i_far.set_tx(1'b1);
        cyc(50);
        check(16'(tx_pin), 16'h0000);
        wr_reg(ust_pkg::ADDR_LCR, 8'h03);
        cyc(3);
        check(16'(tx_pin), 16'h0001);
        // Each low enable bit alone raises the request
        i_far.set_src(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(ust_pkg::ADDR_IER, 8'(1 << i));
            cyc(3);
            check(16'(irq_out), 16'h0001);
        end
        wr_reg(ust_pkg::ADDR_IER, 8'h00);
        cyc(3);
        check(16'(irq_out), 16'h0000);
        i_far.set_src(1'b0);
        // Transmit source alone, gated by its own status
        wr_reg(ust_pkg::ADDR_IER, 8'h02);
        i_far.set_tx_busy(1'b1);
        cyc(3);
        check(16'(irq_out), 16'h0000);
        i_far.set_tx_busy(1'b0);
        cyc(3);
        check(16'(irq_out), 16'h0001);
        wr_reg(ust_pkg::ADDR_IER, 8'h00);
        // Frame lengths: 8N1, 5N1, 5N1.5, 8P2
        brk(8'h03, 160);
        brk(8'h00, 112);
        brk(8'h04, 120);
        brk(8'h0f, 192);
        wr_reg(ust_pkg::ADDR_LCR, 8'h03);
        // Four frames of 160 ticks, divisor one
        i_far.set_fifo(1'b0, 1'b1);
        i_far.stop_pulse();
        cyc(620);
        check(16'(rx_timeout), 16'h0000);
        cyc(40);
        check(16'(rx_timeout), 16'h0001);
        chk_rd(ust_pkg::ADDR_DATA, 8'h00);
        cyc(1);
        check(16'(rx_timeout), 16'h0000);
        cyc(660);
        check(16'(rx_timeout), 16'h0001);
        i_far.stop_pulse();
        cyc(2);
        check(16'(rx_timeout), 16'h0000);
        // Pending receive data keeps the device awake
        wr_reg(ust_pkg::ADDR_IER, 8'h10);
        cyc(10);
        span(10);
        check(16'(de), 16'h000a);
        // Busy transmitter keeps it awake once receive is empty
        i_far.set_tx_busy(1'b1);
        i_far.set_fifo(1'b1, 1'b1);
        cyc(10);
        span(10);
        check(16'(de), 16'h000a);
        i_far.set_tx_busy(1'b0);
        cyc(10);
        span(20);
        check(16'(de), 16'h0000);
        check(16'(dt), 16'h0000);
        // General pin interrupt passes but never wakes
        @(posedge core_clk);
        gpio_irq <= 1'b1;
        span(10);
        check(16'(de), 16'h0000);
        check(16'(irq_out), 16'h0001);
        @(posedge core_clk);
        gpio_irq <= 1'b0;
        // Wake by data write, line edge, modem change, infrared line
        for (int k = 0; k < 4; k++)
        begin
            cyc(20);
            span(5);
            check(16'(de), 16'h0000);
            case (k)
                0: wr_reg(ust_pkg::ADDR_DATA, 8'h5a);
                1: i_far.pulse_line();
                2: i_far.flip_modem();
                default:
                begin
                    @(posedge core_clk);
                    ir_mode <= 1'b1;
                    i_far.pulse_line();
                end
            endcase
            span(10);
            check(16'(de != 0), 16'h0001);
        end
        wr_reg(ust_pkg::ADDR_IER, 8'h00);
        cyc(5);
        test_done();
    end
endmodule

`default_nettype wire
